// >>> lb_monitor.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Every 128 ms cycle, add one if the input failed or was erratic.
// RULE2 - Subtract one per 1, 2, 4 or 8 clean consecutive cycles.
// RULE3 - Two-bit leak code selects 128, 256, 512 or 1024 ms decay.
// RULE4 - Alarm raises when count reaches the upper threshold, 1 to 255.
// RULE5 - Threshold register is eight bits, read/write, resets to six.
// RULE6 - Count is capped at the programmed bucket size.
// RULE7 - Upper six bits of the leak register read zero, ignore writes.
module lb_monitor #(
  parameter int CYCLE_COUNT = lb_pkg::CYCLE_CLKS
) (
  input wire logic clk, // 25 MHz system clock
  input wire logic reset_n, // Async reset, active low
  input wire lb_pkg::reg_req_type req, // Register request
  input wire logic bad_activity, // Input failed or erratic, level
  output logic [7:0] rdata, // Read data, cycle after read strobe
  output logic alarm // Inactivity alarm level
);
  import lb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] leak_code_r;
  logic [7:0] limit_r;
  logic [7:0] size_r;
  logic [7:0] level_r;
  logic [7:0] level_nxt;
  logic [2:0] clean_r;
  logic [2:0] clean_nxt;
  logic seen_bad_r;
  logic tick;

  lb_tick #(.COUNT(CYCLE_COUNT)) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  function automatic logic [2:0] span_last(input logic [1:0] code);
    span_last = 3'((4'h1 << code) - 4'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register writes
  wire wr_leak = req.wr && req.addr == LEAK_INTERVAL_CFG0_ADDR;
  wire wr_limit = req.wr && req.addr == ALARM_RAISE_LIMIT_CFG1_ADDR;
  wire wr_size = req.wr && req.addr == BUCKET_SIZE_ADDR;
  // Zero is outside the legal threshold range and is kept out
  wire limit_ok = req.wdata != 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      leak_code_r <= LEAK_INTERVAL_RESET;
      limit_r <= ALARM_RAISE_LIMIT_RESET;
      size_r <= BUCKET_SIZE_RESET;
    end else begin
      if (wr_leak) leak_code_r <= req.wdata[LEAK_FIELD_MSB:0]; // see RULE7
      if (wr_limit && limit_ok) limit_r <= req.wdata; // see RULE5
      if (wr_size && limit_ok) size_r <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bucket
  wire bad_cycle = seen_bad_r || bad_activity;
  wire span_done = clean_r >= span_last(leak_code_r);

  always_comb begin
    level_nxt = level_r;
    clean_nxt = clean_r;
    if (tick) begin
      if (bad_cycle) begin
        clean_nxt = 3'h0;
        if (level_r < size_r) level_nxt = level_r + 8'h1; // see RULE1 see RULE6
      end else if (span_done) begin
        clean_nxt = 3'h0;
        if (level_r != 8'h00) level_nxt = level_r - 8'h1; // see RULE2 see RULE3
      end else begin
        clean_nxt = clean_r + 3'h1;
      end
    end
    // Shrinking the size trims the level at once
    if (level_nxt > size_r) level_nxt = size_r; // see RULE6
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_r <= 8'h00;
      clean_r <= 3'h0;
      seen_bad_r <= 1'b0;
      alarm <= 1'b0;
    end else begin
      level_r <= level_nxt;
      clean_r <= clean_nxt;
      seen_bad_r <= tick ? 1'b0 : bad_cycle;
      // The alarm follows the level and clears once the level falls below the limit
      alarm <= level_nxt >= limit_r; // see RULE4
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port
  wire [7:0] rd_mux =
    req.addr == LEAK_INTERVAL_CFG0_ADDR ? {6'h00, leak_code_r} : // see RULE7
    req.addr == ALARM_RAISE_LIMIT_CFG1_ADDR ? limit_r :
    req.addr == BUCKET_SIZE_ADDR ? size_r :
    req.addr == STATUS_ADDR ? {7'h00, alarm} :
    req.addr == LEVEL_ADDR ? level_r : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rdata <= 8'h00;
    else rdata <= req.rd ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  a_fill_step: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
    tick && bad_cycle && level_r < size_r |=> level_r == $past(level_r) + 8'h1)
    else $error("bucket did not fill");
  a_cap_hold: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    level_r <= size_r || $changed(size_r)) else $error("bucket above size");
  a_leak_step: assert property (@(posedge clk) disable iff (!reset_n) // see RULE2
    tick && !bad_cycle && span_done && level_r != 8'h00 && level_r <= size_r
    |=> level_r == $past(level_r) - 8'h1) else $error("bucket did not leak");
  a_leak_rate: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    tick && !bad_cycle && !span_done && level_r <= size_r |=> level_r == $past(level_r) || $changed(size_r))
    else $error("leak too fast");
  a_alarm_raise: assert property (@(posedge clk) disable iff (!reset_n) // see RULE4
    alarm == (level_r >= limit_r) || $past(wr_limit)) else $error("alarm mismatch");
  a_limit_range: assert property (@(posedge clk) disable iff (!reset_n) // see RULE5
    limit_r != 8'h00) else $error("threshold zero");
  a_limit_read: assert property (@(posedge clk) disable iff (!reset_n) // see RULE5
    req.rd && req.addr == ALARM_RAISE_LIMIT_CFG1_ADDR && !wr_limit |=> rdata == $past(limit_r))
    else $error("threshold readback wrong");
  a_leak_upper: assert property (@(posedge clk) disable iff (!reset_n) // see RULE7
    req.rd && req.addr == LEAK_INTERVAL_CFG0_ADDR |=> rdata[7:2] == 6'h00)
    else $error("leak upper bits nonzero");

  ////////////////////////////////////////////////////////////////////////
  // Checks: evaluation tick
  // Restarts at one on each tick, so both the first and later ticks land on the period
  logic [31:0] tick_gap_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) tick_gap_r <= 32'h0;
    else tick_gap_r <= tick ? 32'h1 : tick_gap_r + 32'h1;
  end

  a_tick_period: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
    tick == (tick_gap_r == 32'(CYCLE_COUNT)))
    else $error("evaluation tick off period");

  ////////////////////////////////////////////////////////////////////////
  // Checks: register port
  a_leak_write: assert property (@(posedge clk) disable iff (!reset_n) // see RULE7
    wr_leak |=> leak_code_r == $past(req.wdata[LEAK_FIELD_MSB:0]))
    else $error("leak code not written");
  a_leak_hold: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    !wr_leak |=> $stable(leak_code_r))
    else $error("leak code changed unasked");
  a_leak_read: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    req.rd && req.addr == LEAK_INTERVAL_CFG0_ADDR |=> rdata == {6'h00, $past(leak_code_r)})
    else $error("leak readback wrong");
  a_limit_write: assert property (@(posedge clk) disable iff (!reset_n) // see RULE5
    wr_limit && req.wdata != 8'h00 |=> limit_r == $past(req.wdata))
    else $error("threshold not written");
  a_limit_hold: assert property (@(posedge clk) disable iff (!reset_n) // see RULE4
    !wr_limit || req.wdata == 8'h00 |=> $stable(limit_r))
    else $error("threshold changed unasked");
  a_size_write: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    wr_size && req.wdata != 8'h00 |=> size_r == $past(req.wdata))
    else $error("size not written");
  a_size_hold: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    !wr_size || req.wdata == 8'h00 |=> $stable(size_r))
    else $error("size changed unasked");
  a_size_range: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    size_r != 8'h00)
    else $error("size zero");
  a_size_read: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    req.rd && req.addr == BUCKET_SIZE_ADDR |=> rdata == $past(size_r))
    else $error("size readback wrong");
  a_level_read: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    req.rd && req.addr == LEVEL_ADDR |=> rdata == $past(level_r))
    else $error("level readback wrong");
  a_status_read: assert property (@(posedge clk) disable iff (!reset_n) // see RULE4
    req.rd && req.addr == STATUS_ADDR |=> rdata == {7'h00, $past(alarm)})
    else $error("status readback wrong");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!reset_n) // see RULE5
    !req.rd |=> rdata == 8'h00)
    else $error("read data without strobe");

  ////////////////////////////////////////////////////////////////////////
  // Checks: bucket
  a_level_quiet: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
    !tick && level_r <= size_r |=> level_r == $past(level_r))
    else $error("level moved between ticks");
  a_fill_cap: assert property (@(posedge clk) disable iff (!reset_n) // see RULE6
    tick && bad_cycle && level_r >= size_r |=> level_r == $past(size_r))
    else $error("bucket overfilled");
  a_empty_floor: assert property (@(posedge clk) disable iff (!reset_n) // see RULE2
    tick && !bad_cycle && level_r == 8'h00 |=> level_r == 8'h00)
    else $error("bucket leaked below empty");
  a_clean_clear: assert property (@(posedge clk) disable iff (!reset_n) // see RULE2
    tick && bad_cycle |=> clean_r == 3'h0)
    else $error("clean span not restarted");
  a_clean_hold: assert property (@(posedge clk) disable iff (!reset_n) // see RULE2
    !tick |=> $stable(clean_r))
    else $error("clean span moved between ticks");
  a_clean_step: assert property (@(posedge clk) disable iff (!reset_n) // see RULE2
    tick && !bad_cycle && !span_done |=> clean_r == $past(clean_r) + 3'h1)
    else $error("clean span not counted");
  a_bad_latch: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
    !tick && bad_activity |=> seen_bad_r)
    else $error("bad activity lost");
  a_bad_clear: assert property (@(posedge clk) disable iff (!reset_n) // see RULE1
    tick |=> !seen_bad_r)
    else $error("bad activity carried over");
  a_leak_fast: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    tick && !bad_cycle && leak_code_r == 2'h0 && level_r != 8'h00 && level_r <= size_r
    |=> level_r == $past(level_r) - 8'h1) else $error("code zero did not leak");
  a_leak_half: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    tick && !bad_cycle && leak_code_r == 2'h1 && clean_r == 3'h0 && level_r <= size_r
    |=> level_r == $past(level_r)) else $error("code one leaked early");
  a_leak_quarter: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    tick && !bad_cycle && leak_code_r == 2'h2 && clean_r < 3'h3 && level_r <= size_r
    |=> level_r == $past(level_r)) else $error("code two leaked early");
  a_leak_slow: assert property (@(posedge clk) disable iff (!reset_n) // see RULE3
    tick && !bad_cycle && leak_code_r == 2'h3 && clean_r != 3'h7 && level_r <= size_r
    |=> level_r == $past(level_r)) else $error("code three leaked early");
endmodule

// >>> lb_pkg.sv
package lb_pkg;
  // Register indices; byte address equals the printed offset on this plain port
  localparam logic [7:0] LEAK_INTERVAL_CFG0_ADDR = 8'h53;
  localparam logic [7:0] ALARM_RAISE_LIMIT_CFG1_ADDR = 8'h56;
  localparam logic [7:0] BUCKET_SIZE_ADDR = 8'h58;
  localparam logic [7:0] STATUS_ADDR = 8'h59;
  localparam logic [7:0] LEVEL_ADDR = 8'h5A;
  localparam logic [1:0] LEAK_INTERVAL_RESET = 2'h0;
  localparam logic [7:0] ALARM_RAISE_LIMIT_RESET = 8'h06;
  localparam logic [7:0] BUCKET_SIZE_RESET = 8'h08;
  localparam int LEAK_FIELD_MSB = 1;
  localparam int STATUS_ALARM_BIT = 0;
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int CYCLE_MS = 128;
  localparam int CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;
endpackage

// >>> lb_source.sv
`timescale 1ns/1ps
// Failing reference shows short glitches every fourth clock, not a steady level
module lb_source (
  input wire logic clk, // System clock
  input wire logic fail_en, // Make the input erratic
  output logic bad_activity // Failed or erratic indication
);
  logic [1:0] ph_r = 2'h0;
  always @(posedge clk) ph_r <= ph_r + 2'h1;
  assign bad_activity = fail_en && (ph_r == 2'h3);
endmodule

// >>> lb_tick.sv
`timescale 1ns/1ps
module lb_tick #(
  parameter int COUNT = 3200000
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset, active low
  output logic tick // One-cycle pulse each evaluation cycle
);
  logic [31:0] cnt_r;
  wire last = (cnt_r == 32'(COUNT - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt_r <= last ? 32'h0 : cnt_r + 32'h1;
      tick <= last;
    end
  end
endmodule

// >>> leaky_bucket_activity_monitor_tb_top.sv
`timescale 1ns/1ps
module leaky_bucket_activity_monitor_tb_top;
  import lb_pkg::*;
  logic clk = 0, reset_n = 0, fail_en = 0, bad_activity, alarm;
  reg_req_type req = '0;
  logic [7:0] rdata;
  int err_count = 0, n_checks = 0, cnt = 0;
  // Address, write flag, write data, expected read
  logic [24:0] rows [12] = '{{8'h56, 1'b0, 8'h00, 8'h06}, {8'h53, 1'b0, 8'h00, 8'h00},
    {8'h5A, 1'b0, 8'h00, 8'h00}, {8'h60, 1'b0, 8'h00, 8'h00}, {8'h53, 1'b1, 8'hFF, 8'h03},
    {8'h56, 1'b1, 8'h00, 8'h06}, {8'h56, 1'b1, 8'h03, 8'h03}, {8'h53, 1'b1, 8'h01, 8'h01},
    {8'h58, 1'b0, 8'h00, 8'h08}, {8'h58, 1'b1, 8'h00, 8'h08}, {8'h59, 1'b0, 8'h00, 8'h00},
    {8'h5A, 1'b1, 8'h55, 8'h00}};
  lb_monitor #(.CYCLE_COUNT(20)) dut_u (.clk(clk), .reset_n(reset_n), .req(req),
    .bad_activity(bad_activity), .rdata(rdata), .alarm(alarm));
  lb_source src_u (.clk(clk), .fail_en(fail_en), .bad_activity(bad_activity));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cnt <= reset_n ? cnt + 1 : 0;
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk1(input string nm, input logic e);
    n_checks++;
    if (alarm !== e) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, alarm);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk8(nm, e, rdata);
  endtask
  // Align to mid-cycle so reads never race an evaluation tick
  task automatic at(input int k);
    while (cnt < k) @(negedge clk);
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][16]) wr(rows[i][24:17], rows[i][15:8]);
      rdc("register", rows[i][24:17], rows[i][7:0]);
    end
    at(50);
    @(posedge clk) fail_en <= 1'b1;
    at(90);
    rdc("level", LEVEL_ADDR, 8'h02);
    chk1("alarm", 1'b0);
    at(110);
    rdc("level", LEVEL_ADDR, 8'h03);
    chk1("alarm", 1'b1);
    rdc("status", STATUS_ADDR, 8'h01);
    at(250);
    rdc("level", LEVEL_ADDR, 8'h08);
    @(posedge clk) fail_en <= 1'b0;
    at(310);
    rdc("level", LEVEL_ADDR, 8'h07);
    at(470);
    chk1("alarm", 1'b1);
    at(510);
    rdc("level", LEVEL_ADDR, 8'h02);
    chk1("alarm", 1'b0);
    // Second reset in mid-run brings back the defaults
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk1("alarm in reset", 1'b0);
    chk8("rdata in reset", 8'h00, rdata);
    reset_n <= 1'b1;
    rdc("limit after reset", ALARM_RAISE_LIMIT_CFG1_ADDR, 8'h06);
    rdc("leak after reset", LEAK_INTERVAL_CFG0_ADDR, 8'h00);
    rdc("level after reset", LEVEL_ADDR, 8'h00);
    // Three bad cycles, then leak at code zero and code three
    @(posedge clk) fail_en <= 1'b1;
    at(45);
    @(posedge clk) fail_en <= 1'b0;
    at(70);
    rdc("level", LEVEL_ADDR, 8'h03);
    at(90);
    rdc("level", LEVEL_ADDR, 8'h02);
    wr(LEAK_INTERVAL_CFG0_ADDR, 8'h03);
    at(230);
    rdc("level", LEVEL_ADDR, 8'h02);
    at(250);
    rdc("level", LEVEL_ADDR, 8'h01);
    chk1("alarm", 1'b0);
    report_and_stop;
  end
endmodule
